//--- lpwm_bank.sv
/*
 led pwm channel bank: register file, shadow commit and shared pwm timebase for 36 sinks.
 register map seen by the write port:
   00        software shutdown, bit 0 low stops every sink
   01 .. 24  duty per channel, channel n at 00 + n, into the holding copy
   25        commit, only the all-zero byte copies holding to active
   26 .. 49  enable (bit 0) and scale (bits 2:1) per channel, channel n at 25 + n
   4A        global blank, bit 0 high darkens every sink
   4B        pwm rate, bit 0 low for the slow rate, high for the fast one
   4F        soft reset, only the all-zero byte returns every register to default
 any other address, and bits above those listed, are dropped without effect.
 timebase: one divider gives a tick every SLOW_DIV or FAST_DIV clocks and an
 eight bit counter steps once per tick, so one pwm period is 256 ticks and every
 sink starts its period on the same count.
 a sink is lit while the counter is below its active duty, so duty 0 stays dark
 and duty 255 is lit for 255 of 256 counts; full brightness is not reachable.
 shutdown, blank and the hw pin only mask the sinks: registers and the counter run on.
 assumes:
   a byte write port fed by a serial slave on the same clock, one byte per strobe;
   the hw shutdown pin is asynchronous and passes two flip-flops before use;
   scale selects and sink bits go straight to the analog current sinks.
*/
// Operation
// - shutdown bit zero means software shutdown
// - eight bit duty per channel, reset zero
// - output on duty/256 of each period
// - duty registers consecutive from lowest address
// - duty and control writes go to holding
// - writing zero to commit copies holding
// - control bit zero enables the channel
// - bits two-one select current scale
// - control registers mapped in channel order
// - global bit set blanks all outputs
// - frequency bit selects 3kHz or 22kHz; the FAST_DIV of 8 at 50 MHz gives about 24.4kHz
// - writing zero to reset clears everything; the divider and pwm counter keep running
// - power-up defaults leave all outputs dark
// - software shutdown switches off all sinks
// - shutdown keeps all register contents
// - low hardware pin means hardware shutdown
// - all channels share one timebase
`timescale 1ns/1ns
`default_nettype none
`include "lpwm_params.svh"
module lpwm_bank #(
    parameter int CHANNELS  = 36,
    parameter int SLOW_DIV  = `LPWM_SLOW_DIV,
    parameter int FAST_DIV  = `LPWM_FAST_DIV
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // register write port
    input  wire logic                    reg_wr,
    input  wire lpwm_pkg::lpwm_byte_t    reg_addr,
    input  wire lpwm_pkg::lpwm_byte_t    reg_wdata,
    // hardware shutdown pin
    input  wire logic                    hw_shutdown_n_pin,
    // led sinks
    output var  logic [CHANNELS-1:0]     led_sink_outputs,
    output var  lpwm_pkg::lpwm_scale_t   current_scale_sel [CHANNELS],
    // status
    output var  logic                    soft_shutdown_n,
    output var  logic                    pwm_freq_sel,
    output var  logic                    hw_shutdown_active
);
    import lpwm_pkg::*;

    typedef struct packed {
        // holding copies, written by the host
        logic [CHANNELS-1:0][7:0] hold_duty;
        logic [CHANNELS-1:0][2:0] hold_ctrl;
        // active copies, loaded only by a commit or cleared by a soft reset
        logic [CHANNELS-1:0][7:0] duty;
        logic [CHANNELS-1:0][2:0] ctrl;
        // global controls
        logic                     soft_shutdown_n;
        logic                     blank;
        logic                     freq;
        // hw shutdown pin synchroniser
        logic [1:0]               pin_sync;
        // shared timebase
        logic [15:0]              div_cnt;
        logic [7:0]               pwm_cnt;
        // registered sink drive
        logic [CHANNELS-1:0]      out;
    } lpwm_state_t;

    lpwm_state_t state;
    lpwm_state_t next_state;
    logic [15:0] div_limit;
    logic        tick;
    logic        hw_on;
    // one strobe per single register, decoded from the write port
    logic                     wr_shutdown;
    logic                     wr_global;
    logic                     wr_freq;
    logic                     wr_commit;
    logic                     wr_reset;
    logic                     sinks_allowed;
    // per-channel strobes and next values, filled by the channel loop
    logic [CHANNELS-1:0]      wr_duty;
    logic [CHANNELS-1:0]      wr_ctrl;
    logic [CHANNELS-1:0][7:0] chan_hold_duty;
    logic [CHANNELS-1:0][2:0] chan_hold_ctrl;
    logic [CHANNELS-1:0]      chan_enabled;
    logic [CHANNELS-1:0]      chan_in_duty;
    logic [CHANNELS-1:0]      chan_out;

    always_comb
    begin
        wr_shutdown   = 1'b0;
        wr_global     = 1'b0;
        wr_freq       = 1'b0;
        wr_commit     = 1'b0;
        wr_reset      = 1'b0;
        // gates shared by all sinks; they mask the drive and leave registers alone
        sinks_allowed = state.soft_shutdown_n && !state.blank && hw_on;
        if (reg_wr)
        begin
            case (reg_addr)
                `LPWM_ADDR_SHUTDOWN:
                begin
                    wr_shutdown = 1'b1;
                end
                `LPWM_ADDR_GLOBAL:
                begin
                    wr_global = 1'b1;
                end
                `LPWM_ADDR_FREQ:
                begin
                    wr_freq = 1'b1;
                end
                // any other byte is dropped here, never kept for a later strobe
                `LPWM_ADDR_COMMIT:
                begin
                    wr_commit = (reg_wdata == `LPWM_TRIGGER_VALUE);
                end
                `LPWM_ADDR_RESET:
                begin
                    wr_reset = (reg_wdata == `LPWM_RESET_BYTE);
                end
                default:
                begin
                    // banked addresses are decoded per channel, the rest are ignored
                    wr_shutdown = 1'b0;
                end
            endcase
        end
    end

    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++)
        begin : g_chan
            // banked registers sit at fixed steps from the first address of each bank
            assign wr_duty[c] = reg_wr
                && (reg_addr == 8'(`LPWM_ADDR_DUTY_FIRST + c));
            assign wr_ctrl[c] = reg_wr
                && (reg_addr == 8'(`LPWM_ADDR_CTRL_FIRST + c));
            // host bytes only reach the holding copy; sinks see them after commit
            assign chan_hold_duty[c] = wr_duty[c] ? reg_wdata : state.hold_duty[c];
            assign chan_hold_ctrl[c] = wr_ctrl[c]
                ? reg_wdata[2:0] : state.hold_ctrl[c];
            assign chan_enabled[c] = sinks_allowed
                && state.ctrl[c][`LPWM_BIT_D0];
            assign chan_in_duty[c] = (state.pwm_cnt < state.duty[c]);
            assign chan_out[c] = chan_enabled[c] && chan_in_duty[c];
        end
    endgenerate

    always_comb
    begin
        div_limit = state.freq ? 16'(FAST_DIV - 1) : 16'(SLOW_DIV - 1);
        // >= so a switch to the faster rate never leaves the divider past its limit
        tick      = (state.div_cnt >= div_limit);
        hw_on     = state.pin_sync[1];
    end

    always_comb
    begin
        next_state = state;
        // first stage only feeds the second
        next_state.pin_sync = {state.pin_sync[0], hw_shutdown_n_pin};
        // one divider and counter for all channels keeps periods aligned
        next_state.div_cnt = tick ? 16'h0000 : state.div_cnt + 16'h0001;
        if (tick)
        begin
            next_state.pwm_cnt = state.pwm_cnt + 8'h01;
        end
        if (wr_shutdown)
        begin
            next_state.soft_shutdown_n = reg_wdata[`LPWM_BIT_D0];
        end
        if (wr_global)
        begin
            next_state.blank = reg_wdata[`LPWM_BIT_D0];
        end
        if (wr_freq)
        begin
            next_state.freq = reg_wdata[`LPWM_BIT_D0];
        end
        // holding copies come from the per-channel decode
        next_state.hold_duty = chan_hold_duty;
        next_state.hold_ctrl = chan_hold_ctrl;
        if (wr_commit)
        begin
            next_state.duty = state.hold_duty;
            next_state.ctrl = state.hold_ctrl;
        end
        // shutdown leaves registers alone, only gates the sinks
        next_state.out = chan_out;
        if (wr_reset)
        begin
            next_state.hold_duty       = '0;
            next_state.hold_ctrl       = '0;
            next_state.duty            = '0;
            next_state.ctrl            = '0;
            next_state.soft_shutdown_n = 1'b0;
            next_state.blank           = 1'b0;
            next_state.freq            = 1'b0;
            next_state.out             = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++)
        begin : g_scale
            assign current_scale_sel[g] =
                state.ctrl[g][`LPWM_SCALE_MSB:`LPWM_SCALE_LSB];
        end
    endgenerate

    assign led_sink_outputs   = state.out;
    assign soft_shutdown_n    = state.soft_shutdown_n;
    assign pwm_freq_sel       = state.freq;
    assign hw_shutdown_active = !state.pin_sync[1];
endmodule : lpwm_bank
`default_nettype wire

//--- lpwm_bank_monitor.sv
/* lpwm_bank port checks, bound below; status outputs lag a write by one edge, the sinks up to two */
`timescale 1ns/1ns
`default_nettype none
module lpwm_bank_monitor (
    input wire logic clk, rst, reg_wr, soft_shutdown_n, pwm_freq_sel, hw_shutdown_active,
    input wire lpwm_pkg::lpwm_byte_t reg_addr, reg_wdata,
    input wire logic [35:0] led_sink_outputs
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire b = reg_wdata[0];
    wire rw = reg_wr && reg_addr == 8'h4F && reg_wdata == 8'h00;
    wire sw = reg_wr && reg_addr == 8'h00;
    wire fw = reg_wr && reg_addr == 8'h4B;
    wire on = |led_sink_outputs;
    sequence s_blank; reg_wr && reg_addr == 8'h4A && b ##1 !reg_wr [*2]; endsequence
    a_shutdown_write: assert property (sw |=> soft_shutdown_n == $past(b))
        else $error("shutdown");
    a_freq_write: assert property (fw |=> pwm_freq_sel == $past(b))
        else $error("freq");
    a_soft_reset: assert property (rw |=> !soft_shutdown_n && !pwm_freq_sel)
        else $error("reset");
    a_shutdown_hold: assert property (!sw && !rw |=> $stable(soft_shutdown_n))
        else $error("shutdown hold");
    a_freq_hold: assert property (!fw && !rw |=> $stable(pwm_freq_sel))
        else $error("freq hold");
    a_run_needs_enable: assert property (on |-> $past(soft_shutdown_n))
        else $error("shutdown dark");
    a_hw_dark: assert property (hw_shutdown_active [*3] |-> !on) else $error("hw");
    a_blank_dark: assert property (s_blank |-> !on) else $error("blank");
endmodule : lpwm_bank_monitor
bind lpwm_bank lpwm_bank_monitor mon (.clk(clk), .rst(rst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .led_sink_outputs(led_sink_outputs),
    .soft_shutdown_n(soft_shutdown_n), .pwm_freq_sel(pwm_freq_sel),
    .hw_shutdown_active(hw_shutdown_active));
`default_nettype wire

//--- lpwm_bank_test.sv
/* random duty and control bytes, on-time counted per sink over whole periods;
 assumes lpwm_host as writer and the monitor bound from its own file */
`timescale 1ns/1ns
`default_nettype none
module lpwm_bank_test;
    import lpwm_pkg::*;
    logic clk = 1'b0, rst = 1'b1, pin = 1'b1, sdn, fs, hwa, reg_wr;
    lpwm_byte_t a, d, du [36];
    lpwm_scale_t sc [36];
    logic [35:0] led;
    logic [2:0] ct [36];
    logic [31:0] s = 32'h056B;
    int num_errors = 0, checks = 0;
    always #10 clk = ~clk;
    lpwm_host h (.clk(clk), .reg_wr(reg_wr), .reg_addr(a), .reg_wdata(d));
    lpwm_bank #(.SLOW_DIV(2), .FAST_DIV(1)) DUT (.clk(clk), .rst(rst), .reg_wr(reg_wr),
        .reg_addr(a), .reg_wdata(d), .hw_shutdown_n_pin(pin), .led_sink_outputs(led),
        .current_scale_sel(sc), .soft_shutdown_n(sdn), .pwm_freq_sel(fs),
        .hw_shutdown_active(hwa));
    function automatic logic [31:0] xs();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [15:0] ex(int i, int m, bit r);
        return (r && ct[i][0]) ? 16'(du[i]) * 16'(m) : 16'h0000;
    endfunction : ex
    task automatic chk(string n, logic [15:0] v, logic [15:0] e);
        checks++;
        if (v !== e) num_errors++;
        if (v !== e) $display("mismatch %s exp %0h seen %0h", n, e, v);
    endtask : chk
    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    // any window of whole periods holds exactly m times duty on-cycles, whatever its phase
    task automatic wm(lpwm_byte_t ad, lpwm_byte_t dt, int m, bit r);
        logic [15:0] c [36] = '{default: 16'h0000};
        h.wr(ad, dt);
        repeat (8) @(negedge clk);
        repeat (256 * m) @(negedge clk)
            for (int i = 0; i < 36; i++) c[i] += 16'(led[i]);
        for (int i = 0; i < 36; i++) chk("on", c[i], ex(i, m, r));
    endtask : wm
    initial
    begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        chk("dark", 16'({sdn, fs, |led}), 16'h0000);
        for (int i = 0; i < 9 && hwa !== 1'b0; i++) @(negedge clk);
        chk("hw", 16'(hwa), 16'h0000);
        if (num_errors > 0) conclude();
        h.wr(8'h00, 8'h01);
        for (int i = 0; i < 36; i++)
        begin
            s = xs();
            du[i] = i == 0 ? 8'h00 : i == 35 ? 8'hFF : s[7:0];
            ct[i] = i == 35 ? 3'h1 : i == 34 ? 3'h7 : s[10:8];
            h.wr(8'(i + 8'h01), du[i]);
            h.wr(8'(i + 8'h26), {s[15:11], ct[i]});
        end
        wm(8'h25, 8'h01, 2, 1'b0);
        h.wr(8'h25, 8'h00);
        for (int i = 0; i < 36; i++) chk("sc", 16'(sc[i]), 16'(ct[i][2:1]));
        wm(8'h4C, 8'h01, 2, 1'b1);
        wm(8'h4B, 8'h01, 1, 1'b1);
        chk("fs", 16'(fs), 16'h0001);
        wm(8'h4A, 8'h01, 1, 1'b0);
        pin = 1'b0;
        wm(8'h4A, 8'h00, 1, 1'b0);
        pin = 1'b1;
        wm(8'h00, 8'h00, 1, 1'b0);
        wm(8'h00, 8'h01, 1, 1'b1);
        h.wr(8'h4F, 8'h00);
        chk("rst", 16'({sdn, fs, |led}), 16'h0000);
        for (int i = 0; i < 36; i++) chk("rst sc", 16'(sc[i]), 16'h0000);
        h.wr(8'h25, 8'h00);
        wm(8'h00, 8'h01, 1, 1'b0);
        conclude();
    end
endmodule : lpwm_bank_test
`default_nettype wire

//--- lpwm_host.sv
/* byte writer standing in for the serial master; drives on falling edges */
`timescale 1ns/1ns
`default_nettype none
module lpwm_host (
    input wire logic clk,
    output var logic reg_wr = 1'b0,
    output var lpwm_pkg::lpwm_byte_t reg_addr = 8'hFF, reg_wdata = 8'hFF
);
    task automatic wr(input lpwm_pkg::lpwm_byte_t a, input lpwm_pkg::lpwm_byte_t d);
        @(negedge clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d}; // no stale byte once released
    endtask : wr
endmodule : lpwm_host
`default_nettype wire

//--- lpwm_params.svh
/*
 led pwm channel bank: register offsets, field positions, reset values, timing counts.
 assumes a 50 MHz system clock.
*/
`ifndef LPWM_PARAMS_SVH
`define LPWM_PARAMS_SVH
`define LPWM_ADDR_SHUTDOWN      8'h00
`define LPWM_ADDR_DUTY_FIRST    8'h01
`define LPWM_ADDR_COMMIT        8'h25
`define LPWM_ADDR_CTRL_FIRST    8'h26
`define LPWM_ADDR_GLOBAL        8'h4A
`define LPWM_ADDR_FREQ          8'h4B
`define LPWM_ADDR_RESET         8'h4F
`define LPWM_TRIGGER_VALUE      8'h00
`define LPWM_BIT_D0             0
`define LPWM_SCALE_LSB          1
`define LPWM_SCALE_MSB          2
`define LPWM_RESET_BYTE         8'h00
`define LPWM_CLK_HZ             50000000
`define LPWM_SLOW_HZ            3000
`define LPWM_FAST_HZ            22000
`define LPWM_SLOW_DIV           (`LPWM_CLK_HZ / (`LPWM_SLOW_HZ * 256))
`define LPWM_FAST_DIV           (`LPWM_CLK_HZ / (`LPWM_FAST_HZ * 256))
`endif

//--- lpwm_pkg.sv
/*
 led pwm channel bank: types shared by the design.
 assumes lpwm_params.svh for the numbers.
*/
package lpwm_pkg;
    typedef logic [7:0] lpwm_byte_t;
    typedef logic [1:0] lpwm_scale_t;
endpackage : lpwm_pkg
